// ### core/vad_defines.vh
`ifndef VAD_DEFINES_VH
`define VAD_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register subaddresses
`define VAD_SUB_BLACK_LINE  8'h12
`define VAD_SUB_PIN_CTRL    8'h1F
`define VAD_SUB_PROC_STATUS 8'h35
`define VAD_SUB_PROC_RD_PTR 8'h36
`define VAD_SUB_PROC_WR_PTR 8'h37
`define VAD_SUB_PROC_DATA   8'h38

////////////////////////////////////////////////////////////////////////////////
// Pin driver control fields
`define VAD_PIN_SYNC_STR    2:0
`define VAD_PIN_AVO_OFF     3
`define VAD_PIN_SYNC_OFF    4
`define VAD_PIN_VALIGN      5
`define VAD_PIN_CLKA_OFF    6
`define VAD_PIN_CLKB_OFF    7
`define VAD_PIN_DATA_STR    10:8
`define VAD_PIN_DATA_EN     11
`define VAD_PIN_PULLUP_SEL  12
`define VAD_PIN_CLKA_STR    15:14
`define VAD_PIN_RESET       16'h0000
`define VAD_PIN_WR_MASK     16'hDFFF
`define VAD_STRENGTH_HIZ    3'h7

////////////////////////////////////////////////////////////////////////////////
// Status bits, black line reload and serial constants
`define VAD_STA_WR_REQ      0
`define VAD_STA_RD_REQ      1
`define VAD_STA_BUSY        2
`define VAD_BLACK_RELOAD    7'h7F
`define VAD_DEV_ADDR        7'h47
`define VAD_IDLE_BYTE       8'hFF

`endif

// ### core/vad_serial_port.v
`timescale 1ns/100ps
`default_nettype none
`include "vad_defines.vh"

// Byte-level two-wire slave; pins are taken as synchronous samples
module vad_serial_port #(
	parameter [6:0] DEV_ADDR = `VAD_DEV_ADDR
) (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       srst,
	// Bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output reg        sda_oe,
	// Byte events toward the register bank
	output reg        bus_start,
	output reg        rd_begin,
	output reg        rd_next,
	output reg        wr_valid,
	output reg  [7:0] wr_byte,
	input  wire       ack_ok,
	input  wire [7:0] tx_byte
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ACKA = 3'h2;
	localparam [2:0] ST_WR   = 3'h3;
	localparam [2:0] ST_ACKW = 3'h4;
	localparam [2:0] ST_RD   = 3'h5;
	localparam [2:0] ST_ACKR = 3'h6;

	reg       scl_q;     // Previous clock sample
	reg       sda_q;     // Previous data sample
	reg [2:0] state_reg; // Bit-level state
	reg [3:0] bit_cnt;   // Bits of the current byte
	reg [7:0] sh_reg;    // Receive or transmit shifter
	reg       rw_reg;    // Direction bit of the address byte
	reg       mack_reg;  // Master acknowledged last read byte

	wire start_c = scl_q & scl_in & sda_q & ~sda_in;
	wire stop_c  = scl_q & scl_in & ~sda_q & sda_in;
	wire rise    = ~scl_q & scl_in;
	wire fall    = scl_q & ~scl_in;

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Start/stop detect, shifting and acknowledge on clock edges
	always @(posedge sys_clk)
	begin
		bus_start <= 1'b0;
		rd_begin  <= 1'b0;
		rd_next   <= 1'b0;
		wr_valid  <= 1'b0;
		if (srst)
		begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			state_reg <= ST_IDLE;
			bit_cnt   <= 4'h0;
			sh_reg    <= 8'h00;
			rw_reg    <= 1'b0;
			mack_reg  <= 1'b0;
			sda_oe    <= 1'b0;
			wr_byte   <= 8'h00;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (start_c)
			begin
				// Repeated start also lands here
				state_reg <= ST_ADDR;
				bit_cnt   <= 4'h0;
				sda_oe    <= 1'b0;
				bus_start <= 1'b1;
			end
			else if (stop_c)
			begin
				state_reg <= ST_IDLE;
				sda_oe    <= 1'b0;
			end
			else if (rise)
			begin
				case (state_reg)
					ST_ADDR, ST_WR:
					begin
						sh_reg  <= {sh_reg[6:0], sda_in};
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_RD:   bit_cnt  <= bit_cnt + 4'h1;
					ST_ACKR: mack_reg <= ~sda_in;
					default: bit_cnt  <= bit_cnt;
				endcase
			end
			else if (fall)
			begin
				case (state_reg)
					ST_ADDR:
					begin
						if (bit_cnt == 4'h8)
						begin
							// Foreign address: go quiet until next start
							if (sh_reg[7:1] == DEV_ADDR)
							begin
								sda_oe    <= 1'b1;
								rw_reg    <= sh_reg[0];
								rd_begin  <= sh_reg[0];
								state_reg <= ST_ACKA;
							end
							else
								state_reg <= ST_IDLE;
						end
					end
					ST_ACKA, ST_ACKR:
					begin
						bit_cnt <= 4'h0;
						if (state_reg == ST_ACKA && !rw_reg)
						begin
							sda_oe    <= 1'b0;
							state_reg <= ST_WR;
						end
						else if (state_reg == ST_ACKA || mack_reg)
						begin
							// Load the next byte, drive its MSB
							sh_reg    <= tx_byte;
							sda_oe    <= ~tx_byte[7];
							rd_next   <= 1'b1;
							state_reg <= ST_RD;
						end
						else
						begin
							sda_oe    <= 1'b0;
							state_reg <= ST_IDLE;
						end
					end
					ST_WR:
					begin
						if (bit_cnt == 4'h8)
						begin
							wr_valid  <= 1'b1;
							wr_byte   <= sh_reg;
							sda_oe    <= ack_ok;
							state_reg <= ack_ok ? ST_ACKW : ST_IDLE;
						end
					end
					ST_ACKW:
					begin
						sda_oe    <= 1'b0;
						bit_cnt   <= 4'h0;
						state_reg <= ST_WR;
					end
					ST_RD:
					begin
						if (bit_cnt == 4'h8)
						begin
							sda_oe    <= 1'b0;
							state_reg <= ST_ACKR;
						end
						else
						begin
							sh_reg <= {sh_reg[6:0], 1'b0};
							sda_oe <= ~sh_reg[6];
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ### core/vad_aux_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "vad_defines.vh"

module vad_aux_regs #(
	parameter       PTR_W    = 9,
	parameter       DATA_W   = 12,
	parameter [6:0] DEV_ADDR = `VAD_DEV_ADDR
) (
	// Clock and reset
	input  wire              sys_clk,
	input  wire              srst,
	// Serial bus pins
	input  wire              scl_in,
	input  wire              sda_in,
	output wire              sda_out,
	output wire              sda_oe,
	// Firmware processor memory side
	output reg               proc_wr_req,
	output reg  [PTR_W-1:0]  proc_wr_addr,
	output reg  [DATA_W-1:0] proc_wr_data,
	input  wire              proc_wr_done,
	output reg               proc_rd_req,
	output wire [PTR_W-1:0]  proc_rd_addr,
	input  wire [DATA_W-1:0] proc_rd_data,
	input  wire              proc_rd_done,
	input  wire              proc_busy,
	// Black line detector
	input  wire              det_valid,
	input  wire [6:0]        det_lower,
	input  wire [6:0]        det_upper,
	input  wire              det_black,
	output reg               det_restart,
	// Sync sources and test strap
	input  wire              hs_in,
	input  wire              vs_in,
	input  wire              interlace_out_in,
	input  wire              test_in,
	// Pad driver controls
	output wire [2:0]        sync_pin_strength,
	output wire              other_sync_oe,
	output wire              active_video_oe,
	output wire              pixclk_a_oe,
	output wire              pixclk_b_oe,
	output wire [1:0]        pixclk_a_strength,
	output wire [2:0]        data_pin_strength,
	output wire              data_pin_oe,
	output wire              data_pullup_en,
	// Aligned vertical outputs
	output reg               vert_sync_out,
	output reg               interlace_out
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam [1:0] PH_SUB  = 2'h0; // Expect subaddress
	localparam [1:0] PH_HI   = 2'h1; // Expect upper data byte
	localparam [1:0] PH_LO   = 2'h2; // Expect lower data byte
	localparam [1:0] PH_DONE = 2'h3; // Word taken, refuse more

	wire             bus_start; // Start or repeated start
	wire             rd_begin;  // Address matched, read
	wire             rd_next;   // Port took one byte
	wire             wr_valid;  // One byte received
	wire [7:0]       wr_byte;   // Received byte
	wire             ack_ok;    // Accept the next write byte
	reg  [7:0]       tx_byte;   // Byte offered to the port

	reg  [1:0]       phase_reg; // Write byte position
	reg  [7:0]       sub_reg;   // Current subaddress
	reg  [7:0]       hi_reg;    // Held upper byte
	reg  [15:0]      snap_reg;  // Read word snapshot
	reg  [1:0]       idx_reg;   // Read bytes handed out
	reg  [15:0]      rd_word;   // Live read mux

	reg  [15:0]      pin_reg;   // Pin driver control
	reg  [PTR_W-1:0] rd_ptr;    // Read pointer
	reg  [PTR_W-1:0] wr_ptr;    // Write pointer
	reg  [DATA_W-1:0] rd_buf;   // Prefetched read data
	reg  [6:0]       low_cnt;   // Lower black count
	reg  [6:0]       up_cnt;    // Upper black count
	reg              blk_flag;  // Black picture flag
	reg              hs_q;      // Previous sync sample

	// Narrow registers carry one byte, all others two
	function is_wide;
		input [7:0] sub;
		begin
			is_wide = (sub != `VAD_SUB_PROC_STATUS);
		end
	endfunction

	wire [15:0] wr_word   = {hi_reg, wr_byte};
	wire        commit    = wr_valid && (phase_reg == PH_LO);
	wire        rd_last   = rd_next && (idx_reg == {1'b0, is_wide(sub_reg)});
	wire        take_data = rd_last && (sub_reg == `VAD_SUB_PROC_DATA);
	wire        take_blk  = rd_last && (sub_reg == `VAD_SUB_BLACK_LINE);
	wire        hs_rise   = hs_in & ~hs_q;

	////////////////////////////////////////////////////////////////////////////
	// Serial port

	vad_serial_port #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.scl_in    (scl_in),
		.sda_in    (sda_in),
		.sda_out   (sda_out),
		.sda_oe    (sda_oe),
		.bus_start (bus_start),
		.rd_begin  (rd_begin),
		.rd_next   (rd_next),
		.wr_valid  (wr_valid),
		.wr_byte   (wr_byte),
		.ack_ok    (ack_ok),
		.tx_byte   (tx_byte)
	);

	// A second word in one transaction is refused by NACK
	assign ack_ok = (phase_reg != PH_DONE);

	////////////////////////////////////////////////////////////////////////////
	// Subaddress and byte pairing, upper byte first
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			phase_reg <= PH_SUB;
			sub_reg   <= 8'h00;
			hi_reg    <= 8'h00;
		end
		else if (bus_start)
			// Subaddress survives a repeated start for reads
			phase_reg <= PH_SUB;
		else if (wr_valid)
		begin
			case (phase_reg)
				PH_SUB:
				begin
					sub_reg   <= wr_byte;
					phase_reg <= PH_HI;
				end
				PH_HI:
				begin
					hi_reg    <= wr_byte;
					phase_reg <= PH_LO;
				end
				default: phase_reg <= PH_DONE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read word selection; write-only and unmapped read as zero
	always @*
	begin
		case (sub_reg)
			`VAD_SUB_BLACK_LINE:  rd_word = {blk_flag, up_cnt, 1'b0, low_cnt};
			`VAD_SUB_PIN_CTRL:    rd_word = pin_reg;
			`VAD_SUB_PROC_STATUS: rd_word = {8'h00, 5'h00, proc_busy,
				proc_rd_req, proc_wr_req};
			`VAD_SUB_PROC_DATA:   rd_word = {{(16-DATA_W){1'b0}}, rd_buf};
			default:              rd_word = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Snapshot at read start so both bytes belong to one word
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			snap_reg <= 16'h0000;
			idx_reg  <= 2'h0;
		end
		else if (rd_begin)
		begin
			snap_reg <= rd_word;
			idx_reg  <= 2'h0;
		end
		else if (rd_next && idx_reg != 2'h2)
			idx_reg <= idx_reg + 2'h1;
	end

	// Bytes beyond the register's width read as idle ones
	always @*
	begin
		if (is_wide(sub_reg))
		begin
			case (idx_reg)
				2'h0:    tx_byte = snap_reg[15:8];
				2'h1:    tx_byte = snap_reg[7:0];
				default: tx_byte = `VAD_IDLE_BYTE;
			endcase
		end
		else
			tx_byte = (idx_reg == 2'h0) ? snap_reg[7:0] : `VAD_IDLE_BYTE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin driver control register, reserved bit 13 kept at zero
	always @(posedge sys_clk)
	begin
		if (srst)
			pin_reg <= `VAD_PIN_RESET;
		else if (commit && sub_reg == `VAD_SUB_PIN_CTRL)
			pin_reg <= wr_word & `VAD_PIN_WR_MASK;
	end

	// Strength code 7 floats the pin as well as the disable bits
	assign sync_pin_strength = pin_reg[`VAD_PIN_SYNC_STR];
	assign other_sync_oe     = ~pin_reg[`VAD_PIN_SYNC_OFF] &&
		(sync_pin_strength != `VAD_STRENGTH_HIZ);
	assign active_video_oe   = ~pin_reg[`VAD_PIN_AVO_OFF] &&
		(sync_pin_strength != `VAD_STRENGTH_HIZ);
	assign pixclk_a_oe       = ~pin_reg[`VAD_PIN_CLKA_OFF];
	assign pixclk_b_oe       = ~pin_reg[`VAD_PIN_CLKB_OFF];
	assign pixclk_a_strength = pin_reg[`VAD_PIN_CLKA_STR];
	assign data_pin_strength = pin_reg[`VAD_PIN_DATA_STR];
	assign data_pin_oe       = pin_reg[`VAD_PIN_DATA_EN] &&
		(data_pin_strength != `VAD_STRENGTH_HIZ);
	// Pull-up can only be switched off while the test strap is low
	assign data_pullup_en    = ~pin_reg[`VAD_PIN_PULLUP_SEL] | test_in;

	////////////////////////////////////////////////////////////////////////////
	// Vertical outputs: follow horizontal sync edges, or pass straight
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			hs_q          <= 1'b0;
			vert_sync_out <= 1'b0;
			interlace_out <= 1'b0;
		end
		else
		begin
			hs_q <= hs_in;
			if (pin_reg[`VAD_PIN_VALIGN] || hs_rise)
			begin
				vert_sync_out <= vs_in;
				interlace_out <= interlace_out_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read pointer and prefetch; address bits above 8 are dropped
	assign proc_rd_addr = rd_ptr;

	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			rd_ptr      <= {PTR_W{1'b0}};
			proc_rd_req <= 1'b0;
			rd_buf      <= {DATA_W{1'b0}};
		end
		else
		begin
			if (proc_rd_done)
				rd_buf <= proc_rd_data;
			// New request wins over a completion in the same cycle
			if (commit && sub_reg == `VAD_SUB_PROC_RD_PTR)
			begin
				// Host is expected to have seen busy clear first
				rd_ptr      <= wr_word[PTR_W-1:0];
				proc_rd_req <= 1'b1;
			end
			else if (take_data)
			begin
				rd_ptr      <= rd_ptr + 1'b1;
				proc_rd_req <= 1'b1;
			end
			else if (proc_rd_done)
				proc_rd_req <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write pointer and posted writes to processor memory
	always @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_ptr       <= {PTR_W{1'b0}};
			proc_wr_req  <= 1'b0;
			proc_wr_addr <= {PTR_W{1'b0}};
			proc_wr_data <= {DATA_W{1'b0}};
		end
		else
		begin
			// Completion clears even during a pointer write, else the request sticks
			if (proc_wr_done)
				proc_wr_req <= 1'b0;
			if (commit && sub_reg == `VAD_SUB_PROC_WR_PTR)
				wr_ptr <= wr_word[PTR_W-1:0];
			else if (commit && sub_reg == `VAD_SUB_PROC_DATA)
			begin
				// New request wins over a completion in the same cycle
				proc_wr_addr <= wr_ptr;
				proc_wr_data <= wr_word[DATA_W-1:0];
				proc_wr_req  <= 1'b1;
				wr_ptr       <= wr_ptr + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Black line result; writes to it are simply dropped
	always @(posedge sys_clk)
	begin
		det_restart <= 1'b0;
		if (srst)
		begin
			low_cnt  <= `VAD_BLACK_RELOAD;
			up_cnt   <= `VAD_BLACK_RELOAD;
			blk_flag <= 1'b0;
		end
		else if (take_blk)
		begin
			// Reload wins over a detector update in the same cycle
			low_cnt     <= `VAD_BLACK_RELOAD;
			up_cnt      <= `VAD_BLACK_RELOAD;
			blk_flag    <= 1'b0;
			det_restart <= 1'b1;
		end
		else if (det_valid)
		begin
			low_cnt  <= det_lower;
			up_cnt   <= det_upper;
			blk_flag <= det_black;
		end
	end

endmodule
`default_nettype wire

// ### tb/vad_aux_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none

// Port-level checker for the auxiliary register bank
module vad_aux_regs_chk (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       srst,
	// Serial pins and straps
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic       test_in,
	input wire logic       vs_in,
	input wire logic       interlace_out_in,
	// Processor memory handshake
	input wire logic       proc_wr_req,
	input wire logic       proc_wr_done,
	input wire logic       proc_rd_req,
	input wire logic       proc_rd_done,
	input wire logic       det_restart,
	// Pad controls and aligned outputs
	input wire logic [2:0] sync_pin_strength,
	input wire logic       other_sync_oe,
	input wire logic       active_video_oe,
	input wire logic       pixclk_a_oe,
	input wire logic       pixclk_b_oe,
	input wire logic [2:0] data_pin_strength,
	input wire logic       data_pin_oe,
	input wire logic       data_pullup_en,
	input wire logic       vert_sync_out,
	input wire logic       interlace_out
);
	// Single domain, so one clock and one disable for everything
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////////////
	// Pad controls
	a_reset_pads: assert property (
		$fell(srst) |-> sync_pin_strength == 3'h0 && data_pin_strength == 3'h0
			&& !data_pin_oe && pixclk_a_oe && pixclk_b_oe && other_sync_oe
	) else $error("Pad controls not cleared by reset");
	a_sync_hiz: assert property (
		sync_pin_strength == 3'h7 |-> !other_sync_oe && !active_video_oe
	) else $error("Sync pins driven at strength code 7");
	a_data_drive: assert property (
		data_pin_oe |-> data_pin_strength != 3'h7
	) else $error("Data pins driven at strength code 7");
	a_strap_pullup: assert property (
		test_in |-> data_pullup_en
	) else $error("Pull-up dropped while test strap high");
	// A pin write commits only in the low phase after a byte ends
	a_pad_commit: assert property (
		$changed(data_pin_strength) || $changed(sync_pin_strength) |-> !scl_in
	) else $error("Pad control changed outside a byte boundary");

	////////////////////////////////////////////////////////////////////////////////
	// Memory requests hold until answered
	a_wr_hold: assert property (
		proc_wr_req && !proc_wr_done |=> proc_wr_req
	) else $error("Write request dropped before done");
	a_rd_hold: assert property (
		proc_rd_req && !proc_rd_done |=> proc_rd_req
	) else $error("Read request dropped before done");

	////////////////////////////////////////////////////////////////////////////////
	// Detector restart, vertical outputs and bus driver timing
	a_restart_pulse: assert property (
		det_restart |-> !scl_in ##1 !det_restart
	) else $error("Restart pulse misplaced or too long");
	// Both update together from the inputs of the cycle before
	a_vert_source: assert property (
		$changed({vert_sync_out, interlace_out})
			|-> {vert_sync_out, interlace_out} == $past({vs_in, interlace_out_in})
	) else $error("Vertical outputs not taken from inputs");
	a_sda_on_low: assert property (
		$changed(sda_oe) |-> !scl_in && !$past(scl_in)
	) else $error("Data line changed while bus clock high");

	c_ack: cover property ($rose(sda_oe));
	c_restart: cover property (det_restart);
	c_both_pending: cover property (proc_wr_req && proc_rd_req);
endmodule

bind vad_aux_regs vad_aux_regs_chk u_chk (.sys_clk, .srst, .scl_in, .sda_oe, .test_in,
	.vs_in, .interlace_out_in, .proc_wr_req, .proc_wr_done, .proc_rd_req, .proc_rd_done,
	.det_restart, .sync_pin_strength, .other_sync_oe, .active_video_oe, .pixclk_a_oe,
	.pixclk_b_oe, .data_pin_strength, .data_pin_oe, .data_pullup_en, .vert_sync_out,
	.interlace_out);

`default_nettype wire

// ### tb/vad_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "vad_defines.vh"

// Host controller: master on the two-wire bus, Q clocks per phase
module vad_host_model #(
	parameter int Q = 4
) (
	// Clock
	input  wire logic clk,
	// Bus pins; the line itself is pulled up outside
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda
);
	logic ack;	// All bytes written by the host in the last register access acked

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// One bit: data set in the low phase, sampled at the end of high
	task automatic bitc(input logic d, output logic s);
		@(posedge clk) sda_low <= !d;
		repeat (Q) @(posedge clk);
		scl <= 1'b1;
		repeat (Q) @(posedge clk);
		s = sda;
		scl <= 1'b0;
		repeat (Q) @(posedge clk);
	endtask

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		@(posedge clk) sda_low <= 1'b0;
		repeat (Q) @(posedge clk);
		scl <= 1'b1;
		repeat (Q) @(posedge clk);
		sda_low <= 1'b1;
		repeat (Q) @(posedge clk);
		scl <= 1'b0;
	endtask

	// Stop: data rises while the clock is high, bus left idle
	task automatic stop();
		@(posedge clk) sda_low <= 1'b1;
		repeat (Q) @(posedge clk);
		scl <= 1'b1;
		repeat (Q) @(posedge clk);
		sda_low <= 1'b0;
		repeat (Q) @(posedge clk);
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ok);
		logic s;
		for (int i = 7; i >= 0; i--) bitc(b[i], s);
		bitc(1'b1, s);
		ok = !s;
	endtask

	// Last byte is refused so the slave lets go of the line
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bitc(1'b1, b[i]);
		bitc(last, s);
	endtask

	// One word per transaction, upper byte first
	task automatic wreg(input logic [7:0] sub, input logic [15:0] w);
		logic a0, a1, a2, a3;
		start();
		wbyte({`VAD_DEV_ADDR, 1'b0}, a0);
		wbyte(sub, a1);
		wbyte(w[15:8], a2);
		wbyte(w[7:0], a3);
		stop();
		ack = a0 & a1 & a2 & a3;
	endtask

	// Subaddress, repeated start, then n bytes gathered upper first
	task automatic rreg(input logic [7:0] sub, input int n, output logic [15:0] w);
		logic a0, a1, a2;
		logic [7:0] b;
		w = 16'h0000;
		start();
		wbyte({`VAD_DEV_ADDR, 1'b0}, a0);
		wbyte(sub, a1);
		start();
		wbyte({`VAD_DEV_ADDR, 1'b1}, a2);
		for (int i = 0; i < n; i++)
		begin
			rbyte(i == n - 1, b);
			w = {w[7:0], b};
		end
		stop();
		ack = a0 & a1 & a2;
	endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	typedef struct packed {logic [15:0] wr, rb, pd;} vad_row_t;

	// Design inputs, all given a value at time zero
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        proc_wr_done = 1'b0;
	logic [11:0] proc_rd_data = 12'h000;
	logic        proc_rd_done = 1'b0;
	logic        proc_busy = 1'b0;
	logic        det_valid = 1'b0;
	logic [6:0]  det_lower = 7'h00;
	logic [6:0]  det_upper = 7'h00;
	logic        det_black = 1'b0;
	logic        hs_in = 1'b0;
	logic        vs_in = 1'b0;
	logic        interlace_out_in = 1'b0;
	logic        test_in = 1'b0;
	// Design outputs and bench state
	wire logic        scl, sda_low, sda_out, sda_oe, proc_wr_req, proc_rd_req, det_restart;
	wire logic [8:0]  proc_wr_addr, proc_rd_addr;
	wire logic [11:0] proc_wr_data;
	wire logic [2:0]  sync_pin_strength, data_pin_strength;
	wire logic [1:0]  pixclk_a_strength;
	wire logic        other_sync_oe, active_video_oe, pixclk_a_oe, pixclk_b_oe;
	wire logic        data_pin_oe, data_pullup_en, vert_sync_out, interlace_out;
	wire logic        sda_line = !(sda_low | sda_oe);	// Open drain with pull-up
	wire logic [15:0] pads = {2'b00, sync_pin_strength, other_sync_oe, active_video_oe,
		pixclk_a_oe, pixclk_b_oe, pixclk_a_strength, data_pin_strength, data_pin_oe,
		data_pullup_en};
	logic hold = 1'b0;	// Holds back memory answers to keep requests pending
	int   errors = 0;
	int   n_checks = 0;
	int   n_rst = 0;
	int   cyc = 0;
	// Pin control writes: value, readback, pad vector
	vad_row_t rows [6] = '{'{16'h0000, 16'h0000, 16'h0781}, '{16'hFFFF, 16'hDFFF, 16'h387C},
		'{16'h0806, 16'h0806, 16'h3783}, '{16'h1007, 16'h1007, 16'h3980},
		'{16'h2AD8, 16'h0AD8, 16'h000B}, '{16'h8F21, 16'h8F21, 16'h0FDD}};

	vad_aux_regs dut (.sys_clk, .srst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
		.proc_wr_req, .proc_wr_addr, .proc_wr_data, .proc_wr_done, .proc_rd_req,
		.proc_rd_addr, .proc_rd_data, .proc_rd_done, .proc_busy, .det_valid, .det_lower,
		.det_upper, .det_black, .det_restart, .hs_in, .vs_in, .interlace_out_in, .test_in,
		.sync_pin_strength, .other_sync_oe, .active_video_oe, .pixclk_a_oe, .pixclk_b_oe,
		.pixclk_a_strength, .data_pin_strength, .data_pin_oe, .data_pullup_en,
		.vert_sync_out, .interlace_out);
	vad_host_model host (.clk(sys_clk), .scl, .sda_low, .sda(sda_line));

	always #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Memory side answers next cycle; memory word is its address plus A00
	always @(posedge sys_clk)
	begin
		proc_wr_done <= !hold && proc_wr_req && !proc_wr_done;
		proc_rd_done <= !hold && proc_rd_req && !proc_rd_done;
		proc_rd_data <= 12'hA00 | {3'h0, proc_rd_addr};
		n_rst <= n_rst + int'(det_restart);
		cyc <= cyc + 1;
		// Cut a hang short
		if (cyc == 60000)
		begin
			errors++;
			final_report();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		logic [15:0] w;
		logic        a;
		logic [7:0]  bb [5];
		bb = '{8'h8E, 8'h1F, 8'h12, 8'h34, 8'h56};
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		host.rreg(8'h1F, 2, w);
		chk("pin reset", 16'h0000, w);
		chk("pads reset", 16'h0781, pads);
		foreach (rows[i])
		begin
			host.wreg(8'h1F, rows[i].wr);
			chk("write ack", 16'h0001, 16'(host.ack));
			host.rreg(8'h1F, 2, w);
			chk("pin readback", rows[i].rb, w);
			chk("pad outputs", rows[i].pd, pads);
		end
		// Pull-up select only holds while the strap is low
		host.wreg(8'h1F, 16'h1000);
		chk("pullup off", 16'h0000, 16'(data_pullup_en));
		test_in <= 1'b1;
		@(posedge sys_clk);
		chk("pullup strap", 16'h0001, 16'(data_pullup_en));
		// Aligned vertical outputs wait for a horizontal sync edge
		vs_in <= 1'b1;
		interlace_out_in <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("vert wait", 16'h0000, 16'({vert_sync_out, interlace_out}));
		hs_in <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("vert aligned", 16'h0003, 16'({vert_sync_out, interlace_out}));
		hs_in <= 1'b0;
		vs_in <= 1'b0;
		interlace_out_in <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("vert held", 16'h0003, 16'({vert_sync_out, interlace_out}));
		host.wreg(8'h1F, 16'h0020);
		chk("vert free", 16'h0000, 16'({vert_sync_out, interlace_out}));
		// Prefetch, then two data reads advancing the pointer
		host.wreg(8'h36, 16'h0005);
		chk("rd addr", 16'h0005, 16'(proc_rd_addr));
		host.rreg(8'h36, 2, w);
		chk("pointer write only", 16'h0000, w);
		host.rreg(8'h38, 2, w);
		chk("data first", 16'h0A05, w);
		host.rreg(8'h38, 2, w);
		chk("data second", 16'h0A06, w);
		chk("rd addr advanced", 16'h0007, 16'(proc_rd_addr));
		// Requests held pending; a second write overwrites the first
		hold <= 1'b1;
		proc_busy <= 1'b1;
		host.wreg(8'h37, 16'h01F0);
		host.wreg(8'h38, 16'h0ABC);
		host.wreg(8'h38, 16'h0123);
		chk("wr addr", 16'h01F1, 16'(proc_wr_addr));
		chk("wr data", 16'h0123, 16'(proc_wr_data));
		host.wreg(8'h36, 16'h0010);
		host.rreg(8'h35, 1, w);
		chk("status pending", 16'h0007, w);
		hold <= 1'b0;
		proc_busy <= 1'b0;
		host.rreg(8'h35, 2, w);
		chk("status idle", 16'h00FF, w);
		// Black line result, then its reload on read
		det_lower <= 7'h15;
		det_upper <= 7'h2A;
		det_black <= 1'b1;
		det_valid <= 1'b1;
		@(posedge sys_clk);
		det_valid <= 1'b0;
		host.rreg(8'h12, 2, w);
		chk("black word", 16'hAA15, w);
		chk("restart pulses", 16'h0001, 16'(n_rst));
		host.rreg(8'h12, 2, w);
		chk("black reload", 16'h7F7F, w);
		// Third data byte in one transaction is refused
		host.start();
		foreach (bb[i]) host.wbyte(bb[i], a);
		host.stop();
		chk("burst refused", 16'h0000, 16'(a));
		host.rreg(8'h1F, 2, w);
		chk("burst word", 16'h1234, w);
		// Foreign device address is ignored
		host.start();
		host.wbyte(8'h90, a);
		host.stop();
		chk("foreign address", 16'h0000, 16'(a));
		// Reset in mid-run clears control state again
		chk("sda out", 16'h0000, 16'(sda_out));
		det_valid <= 1'b1;
		@(posedge sys_clk);
		det_valid <= 1'b0;
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		host.rreg(8'h1F, 2, w);
		chk("pin second reset", 16'h0000, w);
		host.rreg(8'h12, 2, w);
		chk("counts second reset", 16'h7F7F, w);
		final_report();
	end
endmodule

`default_nettype wire
